// File: lwsp_pkg.sv
// Shared constants and carriers for the late-write pipelined memory port
package lwsp_pkg;
	localparam int LANES      = 4;
	localparam int LANE_W     = 9;
	localparam int WORD_W     = LANES * LANE_W;
	localparam int ADDR_W     = 19;
	localparam int MAX_ADDR_W = 24;

	// All lane enables high: a write that changes nothing
	localparam logic [LANES-1:0] LANES_NONE_N = 4'hF;

	// Strap levels that select register-register pipelined reads
	localparam logic MODE_LOW_REQ  = 1'h0;
	localparam logic MODE_HIGH_REQ = 1'h1;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0]  lane_we_n;
	} lwsp_cmd_t;

	localparam lwsp_cmd_t CMD_IDLE = '{valid: 1'h0, write: 1'h0, addr: '0, lane_we_n: LANES_NONE_N};

	// Pins that arrive without timing relation to core_clk
	typedef struct packed {
		logic sleep;
		logic mode_lo;
		logic mode_hi;
	} lwsp_pins_t;

	localparam lwsp_pins_t PINS_RESET = '{sleep: 1'h0, mode_lo: MODE_LOW_REQ, mode_hi: MODE_HIGH_REQ};
endpackage

// File: lwsp_lane_array.sv
// Storage array split into byte lanes, with the registered read port
`timescale 1ns/1ps
module lwsp_lane_array #(
	parameter int ADDR_W = lwsp_pkg::ADDR_W,
	parameter int LANES  = lwsp_pkg::LANES,
	parameter int LANE_W = lwsp_pkg::LANE_W
) (
	input  wire logic                      core_clk,
	input  wire logic                      reset,
	input  wire logic [LANES-1:0]          wr_lane_en,
	input  wire logic [ADDR_W-1:0]         wr_addr,
	input  wire logic [LANES*LANE_W-1:0]   wr_data,
	input  wire logic                      rd_en,
	input  wire logic [ADDR_W-1:0]         rd_addr,
	output logic      [LANES*LANE_W-1:0]   rd_q
);
	localparam int DEPTH = 1 << ADDR_W;

	if (ADDR_W < 1 || ADDR_W > lwsp_pkg::MAX_ADDR_W || LANES < 1 || LANE_W < 1) begin : g_bad_cfg
		$error("lwsp_lane_array: unsupported geometry");
	end

	logic [LANES*LANE_W-1:0] lane_rd;
	logic [LANES*LANE_W-1:0] rd_d;

	// =========================================
	// Lanes
	// Each lane owns its own array so a partial write never touches a neighbour
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		logic [LANE_W-1:0] lane_mem [DEPTH];
		always_ff @(posedge core_clk) begin
			if (wr_lane_en[g]) begin
				lane_mem[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
			end
		end
		assign lane_rd[g*LANE_W +: LANE_W] = lane_mem[rd_addr];
	end

	// =========================================
	// Output register
	always_comb begin
		rd_d = rd_en ? lane_rd : rd_q;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rd_q <= '0;
		end else begin
			rd_q <= rd_d;
		end
	end
endmodule

// File: lwsp_port.sv
// Late-write, pipelined-read synchronous memory port, device side
//
// Functional notes
// - The port holds 512K words of 36 bits and picks one word by the address taken with the command.
// - Address and read/write control are latched only on the rising clock edge.
// - A write starts on a rising edge and updates the array internally, with no external pulse.
// - Read data leaves through an output register clocked on the rising edge.
// - A read that follows a pending write to the same word returns the new data.
// - The word is four 9-bit lanes, each written only while its own low-active enable is asserted.
// - Each lane enable belongs to exactly one data lane and low means write permission.
// - With select sampled low, a low write strobe asks for a write and a high one for a read.
// - Data pins drive only while the low-active output enable is low, independent of the clock.
// - A high sleep request puts the port to sleep with all contents kept.
// - A read updates the output register on the edge after the command edge and, unless sleep takes effect on the command edge, drives it under enable.
// - Write data is supplied and sampled on the edge after the one that took address and control.
// - A deselect is pipelined like read data, so the pins float after the following edge.
// - A write with all four lane enables high is an abort and changes no byte.
`timescale 1ns/1ps
module lwsp_port (
	input  wire logic                        core_clk,
	input  wire logic                        reset,
	input  wire logic [lwsp_pkg::ADDR_W-1:0] addr,
	input  wire logic                        select_n,
	input  wire logic                        write_strobe_n,
	input  wire logic [lwsp_pkg::LANES-1:0]  lane_write_enable_n,
	input  wire logic [lwsp_pkg::WORD_W-1:0] dq_i,
	output logic      [lwsp_pkg::WORD_W-1:0] dq_o,
	output logic                             dq_oe,
	input  wire logic                        output_enable_n,
	input  wire logic                        sleep_request,
	input  wire logic                        protocol_select_low,
	input  wire logic                        protocol_select_high,
	output logic                             mode_error
);
	lwsp_pkg::lwsp_pins_t            pins_raw;
	lwsp_pkg::lwsp_pins_t            pins_meta_q;
	lwsp_pkg::lwsp_pins_t            pins_q;
	logic                            sleep_s;
	logic                            mode_error_d;
	logic                            mode_error_q;
	lwsp_pkg::lwsp_cmd_t             cmd_d;
	lwsp_pkg::lwsp_cmd_t             cmd_q;
	logic                            drive_d;
	logic                            drive_q;
	logic                            rd_en;
	logic [lwsp_pkg::LANES-1:0]      wr_lane_en;

	// =========================================
	// Pin synchronisers
	// Sleep and straps are unrelated to core_clk; two stages before use
	assign pins_raw = '{sleep: sleep_request, mode_lo: protocol_select_low, mode_hi: protocol_select_high};

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pins_meta_q <= lwsp_pkg::PINS_RESET;
			pins_q      <= lwsp_pkg::PINS_RESET;
		end else begin
			pins_meta_q <= pins_raw;
			pins_q      <= pins_meta_q;
		end
	end

	assign sleep_s = pins_q.sleep;

	// =========================================
	// Strap check
	// Straps are the board's duty; a wrong level is only reported, never acted on
	always_comb begin
		mode_error_d = (pins_q.mode_lo != lwsp_pkg::MODE_LOW_REQ) ||
		               (pins_q.mode_hi != lwsp_pkg::MODE_HIGH_REQ);
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			mode_error_q <= 1'h0;
		end else begin
			mode_error_q <= mode_error_d;
		end
	end

	assign mode_error = mode_error_q;

	// =========================================
	// Command stage
	always_comb begin
		cmd_d           = lwsp_pkg::CMD_IDLE;
		cmd_d.valid     = !select_n && !sleep_s;
		cmd_d.write     = !write_strobe_n;
		cmd_d.addr      = addr;
		cmd_d.lane_we_n = lane_write_enable_n;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cmd_q <= lwsp_pkg::CMD_IDLE;
		end else begin
			cmd_q <= cmd_d;
		end
	end

	// =========================================
	// Data stage
	// A write taken during the last edge before sleep still completes, so no half-done word is left
	always_comb begin
		wr_lane_en = '0;
		if (cmd_q.valid && cmd_q.write) begin
			wr_lane_en = ~cmd_q.lane_we_n;
		end
		rd_en   = cmd_q.valid && !cmd_q.write;
		// Deselect, write and sleep all release the pins one edge after they are taken
		drive_d = rd_en && !sleep_s;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			drive_q <= 1'h0;
		end else begin
			drive_q <= drive_d;
		end
	end

	// Write data is sampled on the edge after the command edge, and the
	// array is written on that same edge, so a read behind it sees the new word
	lwsp_lane_array #(
		.ADDR_W (lwsp_pkg::ADDR_W),
		.LANES  (lwsp_pkg::LANES),
		.LANE_W (lwsp_pkg::LANE_W)
	) u_array (
		.core_clk   (core_clk),
		.reset      (reset),
		.wr_lane_en (wr_lane_en),
		.wr_addr    (cmd_q.addr),
		.wr_data    (dq_i),
		.rd_en      (rd_en),
		.rd_addr    (cmd_q.addr),
		.rd_q       (dq_o)
	);

	// Output enable is deliberately unclocked
	assign dq_oe = drive_q && !output_enable_n;

	// =========================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_read_drive_timing: assert property (
		(!select_n && write_strobe_n && !sleep_s) ##1 !sleep_s |=> drive_q
	) else $error("read did not drive on the edge after its command");

	a_deselect_release: assert property (
		(select_n && !sleep_s) |=> ##1 !drive_q
	) else $error("pins still driven one edge after a deselect");

	a_write_release: assert property (
		(!select_n && !write_strobe_n) |=> ##1 !drive_q
	) else $error("pins driven after a write command");

	a_oe_gates_pins: assert property (
		dq_oe |-> (!output_enable_n && drive_q)
	) else $error("data pins enabled while output enable is high");

	a_sleep_quiet_pins: assert property (
		sleep_s |=> (!drive_q && !cmd_q.valid)
	) else $error("activity while sleeping");

	a_coherent_readback: assert property (
		(cmd_q.valid && cmd_q.write && cmd_q.lane_we_n == '0) ##1
		(cmd_q.valid && !cmd_q.write && cmd_q.addr == $past(cmd_q.addr)) |=> dq_o == $past(dq_i, 2)
	) else $error("read after write returned stale data");

	a_abort_no_write: assert property (
		(!select_n && !write_strobe_n && lane_write_enable_n == lwsp_pkg::LANES_NONE_N) |=> wr_lane_en == '0
	) else $error("aborted write touched a lane");

	a_lane_mapping: assert property (
		(!select_n && !write_strobe_n && !sleep_s) |=> wr_lane_en == ~$past(lane_write_enable_n)
	) else $error("lane enable did not reach its own lane");

	a_output_hold: assert property (
		!rd_en |=> $stable(dq_o)
	) else $error("output register changed without a read");

	a_strap_flag: assert property (
		(pins_q.mode_lo != lwsp_pkg::MODE_LOW_REQ) |=> mode_error
	) else $error("wrong strap not reported");

	c_read_driven:  cover property (rd_en ##1 dq_oe);
	c_write_read:   cover property ((cmd_q.valid && cmd_q.write) ##1 rd_en);
	c_partial_write: cover property (cmd_q.valid && cmd_q.write && $onehot(wr_lane_en));
	c_sleep_resume: cover property (sleep_s ##1 !sleep_s ##[1:8] dq_oe);
endmodule

// File: lwsp_ctrl_model.sv
// Behavioural cache controller that drives the memory port's pins
`timescale 1ns/1ps
module lwsp_ctrl_model (
	input  wire logic                   core_clk,
	output logic [lwsp_pkg::ADDR_W-1:0] addr,
	output logic                        select_n,
	output logic                        write_strobe_n,
	output logic [lwsp_pkg::LANES-1:0]  lane_write_enable_n,
	output logic [lwsp_pkg::WORD_W-1:0] dq_i,
	output logic                        output_enable_n,
	output logic                        sleep_request,
	output logic                        protocol_select_low,
	output logic                        protocol_select_high
);
	logic                        pend;
	logic [lwsp_pkg::WORD_W-1:0] pend_data;

	initial begin
		addr = '0;
		select_n = 1'h1;
		write_strobe_n = 1'h1;
		lane_write_enable_n = lwsp_pkg::LANES_NONE_N;
		dq_i = '0;
		output_enable_n = 1'h0;
		sleep_request = 1'h0;
		protocol_select_low = lwsp_pkg::MODE_LOW_REQ;
		protocol_select_high = lwsp_pkg::MODE_HIGH_REQ;
		pend = 1'h0;
		pend_data = '0;
	end

	// =====================================================
	// One clock slot: a command, plus late data for the previous write
	task automatic slot(input logic rd, input logic wr, input logic [lwsp_pkg::ADDR_W-1:0] a,
			input logic [lwsp_pkg::LANES-1:0] ln, input logic [lwsp_pkg::WORD_W-1:0] d);
		@(negedge core_clk);
		select_n <= !(rd || wr);
		write_strobe_n <= !wr;
		addr <= (rd || wr) ? a : ~addr;
		lane_write_enable_n <= ln;
		// Unused data lines toggle so a stale value can never pass
		dq_i <= pend ? pend_data : ~dq_i;
		pend <= wr;
		pend_data <= d;
	endtask
endmodule

// File: tb_lwsp_port.sv
// Self-checking bench for the late-write pipelined memory port
`timescale 1ns/1ps
module tb_lwsp_port;
	localparam int W  = lwsp_pkg::WORD_W;
	localparam int AW = lwsp_pkg::ADDR_W;
	logic                     core_clk = 1'h0;
	logic                     reset    = 1'h1;
	logic [AW-1:0]            addr;
	logic                     select_n, write_strobe_n, output_enable_n, sleep_request;
	logic                     protocol_select_low, protocol_select_high, dq_oe, mode_error;
	logic [3:0]               lane_write_enable_n;
	logic [W-1:0]             dq_i, dq_o;
	logic [W-1:0]             exp_q[$];
	logic [W-1:0]             mem[logic [AW-1:0]];
	logic [AW-1:0]            adr[4] = '{19'h00000, 19'h7FFFF, 19'h2AAAA, 19'h55555};
	int                       fail_count = 0;
	int                       checks = 0;

	always #2.5 core_clk = ~core_clk;

	lwsp_ctrl_model lwsp_ctrl_model_inst (.core_clk, .addr, .select_n, .write_strobe_n, .lane_write_enable_n,
		.dq_i, .output_enable_n, .sleep_request, .protocol_select_low, .protocol_select_high);
	lwsp_port lwsp_port_inst (.core_clk, .reset, .addr, .select_n, .write_strobe_n, .lane_write_enable_n,
		.dq_i, .dq_o, .dq_oe, .output_enable_n, .sleep_request, .protocol_select_low, .protocol_select_high,
		.mode_error);

	// =====================================================
	// Shared tasks
	task automatic check(input string what, input logic [W-1:0] e, input logic [W-1:0] s);
		checks++;
		if (e !== s) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, e, s);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	function automatic logic [W-1:0] rnd();
		logic [63:0] r;
		r = {$urandom(), $urandom()};
		return r[W-1:0];
	endfunction

	// Live operations update the shadow copy; dead ones are meant to be ignored
	task automatic wr(input logic [AW-1:0] a, input logic [3:0] ln, input logic [W-1:0] d, input logic live);
		for (int i = 0; i < 4; i++) if (live && !ln[i]) mem[a][i*9 +: 9] = d[i*9 +: 9];
		lwsp_ctrl_model_inst.slot(1'h0, 1'h1, a, ln, d);
	endtask

	task automatic rd(input logic [AW-1:0] a, input logic live);
		if (live) exp_q.push_back(mem[a]);
		lwsp_ctrl_model_inst.slot(1'h1, 1'h0, a, 4'hF, '0);
	endtask

	task automatic idle(input int n);
		repeat (n) lwsp_ctrl_model_inst.slot(1'h0, 1'h0, '0, 4'hF, '0);
	endtask

	task automatic wait_mode(input logic v);
		int n;
		n = 0;
		while (mode_error !== v && n < 8) begin
			@(negedge core_clk);
			n++;
		end
		check("mode_error", {35'h0, v}, {35'h0, mode_error});
	endtask

	// =====================================================
	// Output watcher: every driven cycle must match the oldest note
	always @(negedge core_clk) begin
		if (!reset && dq_oe === 1'h1) begin
			if (exp_q.size() == 0) check("unexpected dq_oe", '0, {35'h0, dq_oe});
			else check("dq_o", exp_q.pop_front(), dq_o);
		end
	end

	initial begin
		#100000;
		fail_count++;
		tally_and_finish();
	end

	// =====================================================
	// Main sequence
	initial begin
		void'($urandom(32'hEEF8));
		repeat (10) @(negedge core_clk);
		check("dq_oe in reset", '0, {35'h0, dq_oe});
		check("dq_o in reset", '0, dq_o);
		reset <= 1'h0;
		for (int i = 0; i < 4; i++) wr(adr[i], 4'h0, rnd(), 1'h1);
		wr(adr[0], 4'h0, rnd(), 1'h1);
		rd(adr[0], 1'h1);
		for (int i = 0; i < 4; i++) begin
			wr(adr[1], 4'(~(4'h1 << i)), rnd(), 1'h1);
			rd(adr[1], 1'h1);
		end
		wr(adr[2], 4'hF, rnd(), 1'h1);
		rd(adr[2], 1'h1);
		idle(3);
		check("notes after abort", '0, W'(exp_q.size()));
		rd(adr[3], 1'h1);
		idle(1);
		check("dq_oe before load", '0, {35'h0, dq_oe});
		@(posedge core_clk);
		#1 lwsp_ctrl_model_inst.output_enable_n = 1'h1;
		#1 check("dq_oe gated", '0, {35'h0, dq_oe});
		lwsp_ctrl_model_inst.output_enable_n = 1'h0;
		#1 check("dq_oe enabled", 36'h1, {35'h0, dq_oe});
		idle(2);
		check("dq_oe after deselect", '0, {35'h0, dq_oe});
		for (int i = 0; i < 40; i++) begin
			if ($urandom() % 2) rd(adr[$urandom() % 4], 1'h1);
			else wr(adr[$urandom() % 4], 4'($urandom()), rnd(), 1'h1);
		end
		idle(3);
		lwsp_ctrl_model_inst.sleep_request <= 1'h1;
		idle(4);
		wr(adr[3], 4'h0, rnd(), 1'h0);
		rd(adr[3], 1'h0);
		idle(3);
		lwsp_ctrl_model_inst.sleep_request <= 1'h0;
		idle(4);
		check("dq_oe after sleep", '0, {35'h0, dq_oe});
		rd(adr[3], 1'h1);
		idle(3);
		lwsp_ctrl_model_inst.protocol_select_low <= 1'h1;
		wait_mode(1'h1);
		lwsp_ctrl_model_inst.protocol_select_low <= lwsp_pkg::MODE_LOW_REQ;
		wait_mode(1'h0);
		check("notes left", '0, W'(exp_q.size()));
		tally_and_finish();
	end
endmodule
